// File: hdl/posl_pkg.sv
// Package: constants for the press option switch logic
package posl_pkg;
   // Clock and tick
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC = (CLK_HZ / 1000000) * TICK_US;
   localparam int unsigned PALM_MS = 500;
   localparam int unsigned CONC_MS = 5000;
   localparam int unsigned PALM_TICKS = PALM_MS * 1000 / TICK_US;
   localparam int unsigned CONC_TICKS = CONC_MS * 1000 / TICK_US;
   // Angles in degrees, 9 bits; stop-time limit 16 bits
   localparam logic [8:0] ANG_TDC = 9'h168;
   localparam logic [8:0] ANG_TSTOP_MIN = 9'h0d3;
   localparam logic [8:0] CARRY_UP_RST = 9'h0b4;
   localparam logic [15:0] STOP_LIMIT_RST = 16'h00c8;
   // Option switch positions in the switch block
   localparam int unsigned SW_FOOT = 2;
   localparam int unsigned SW_COMP = 3;
   localparam int unsigned SW_CONC = 4;
   localparam int unsigned SW_CAM = 5;
   localparam int unsigned SW_LOCK = 6;
   localparam logic [7:0] OPT_RST = 8'h00;
   // Wishbone offsets
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_OPTIONS = 8'h04;
   localparam logic [7:0] A_CARRY = 8'h08;
   localparam logic [7:0] A_STOPLIM = 8'h0c;
   localparam logic [7:0] A_TSTOP = 8'h10;
   localparam logic [7:0] A_CAM0 = 8'h14;
   // Stroke states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_CARRY = 2'b10,
      ST_ESTOP = 2'b11
   } posl_state_type;
endpackage : posl_pkg

// File: hdl/posl_cam_mem.sv
// Small memory holding the cam on and off angles
`timescale 1ns/1ps
`default_nettype none
module posl_cam_mem #(
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [8:0] wdata_i,
   output logic [8:0] rdata_o
);
   logic [8:0] mem [DEPTH];  // Cam angle storage
   // Registered write and read
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
   end
endmodule : posl_cam_mem
`default_nettype wire

// File: hdl/posl_top.sv
// Top: option switch interpretation for a press clutch/brake control
// Function
// R1 - Foot mode switch 3 applies single-stroke only
// R2 - Switch 3 off: momentary pedal completes stroke
// R3 - Switch 3 on: hold pedal through carry-up
// R4 - Early pedal release issues emergency stop
// R5 - Switch 4 selects top-stop compensation
// R6 - Overshoot moves top-stop trigger earlier equally
// R7 - Trigger angle never earlier than 211
// R8 - Compensation refined gradually over several stops
// R9 - Switch 5 off: palms within half second
// R10 - Switch 5 on: all stations within five seconds
// R11 - Expired window refuses press start
// R12 - Each station has own two-hand module
// R13 - Switch 6 gates cam angle changes
// R14 - Switch 7 locks stop limit, carry-up
// R15 - All switches default off, normal operation
// R16 - Switches read only at power-up
// R17 - Windows timed by fixed tick counters
`timescale 1ns/1ps
`default_nettype none
module posl_top
   import posl_pkg::*;
#(
   parameter int NSTAT = 2,
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Operator side; crank angle and at-rest come from the press
   input wire logic [7:0] option_switch_block_i,
   input wire logic foot_mode_i,
   input wire logic single_stroke_i,
   input wire logic foot_pedal_i,
   input wire logic [2*NSTAT-1:0] palm_i,
   input wire logic [NSTAT-1:0] station_present_i,
   input wire logic [8:0] crank_angle_i,
   input wire logic at_rest_i,
   // Press side
   output logic stroke_o,
   output logic estop_o,
   output logic top_stop_o
);
   logic [7:0] opt_q, opt_d;            // Latched switches
   logic strap_done_q, strap_done_d;    // Capture happened
   logic [8:0] carry_q, carry_d;        // Carry-up angle
   logic [15:0] stoplim_q, stoplim_d;   // Stop-time limit
   logic [8:0] tstop_q, tstop_d;        // Top-stop trigger angle
   logic [14:0] tick_cnt_q, tick_cnt_d; // Tick divider, fits a 1 ms count
   logic tick_q, tick_d;                // One-cycle tick
   logic [12:0] win_q, win_d;           // Window counter
   logic win_on_q, win_on_d;            // Window running
   logic blocked_q, blocked_d;          // Wait for all-release
   posl_state_type st_q, st_d;          // Stroke state
   logic stroke_q, stroke_d, estop_q, estop_d, tstop_out_q, tstop_out_d;
   logic rest_q, rest_d;                // Previous at-rest level
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic [8:0] cam_rd;
   logic cam_we;
   logic cam_sel; // Address is a cam word
   logic cam_wait_q, cam_wait_d; // Cam read waits one cycle for memory
   logic wr, rd;
   logic any_palm, all_palm;
   logic [NSTAT-1:0] st_ok;
   logic [12:0] win_lim;
   logic [8:0] over, target;

   // Per-station palm pair combined; absent stations count as satisfied
   genvar g;
   for (g = 0; g < NSTAT; g++) begin : g_st
      assign st_ok[g] = (palm_i[2*g] & palm_i[2*g+1]) | ~station_present_i[g];
   end
   assign all_palm = &st_ok;
   assign any_palm = |palm_i;
   // Window length: concurrent time only with switch 5 on
   assign win_lim = opt_q[SW_CONC] ? 13'(CONC_TICKS) : 13'(PALM_TICKS); // R9 R10

   assign wr = cyc_i & stb_i & we_i & ~ack_q;
   assign rd = cyc_i & stb_i & ~we_i & ~ack_q;
   // Cam words sit at 14, 18 and 1c; word 10 is the top-stop angle
   assign cam_sel = (adr_i[7:4] == A_CAM0[7:4]) & (adr_i[3:2] != 2'h0)
                    & (adr_i[1:0] == 2'h0);
   // Cam writes only while switch 6 is on
   assign cam_we = wr & cam_sel & sel_i[0] & opt_q[SW_CAM]; // R13

   posl_cam_mem #(.DEPTH(4), .AW(2)) u_cam (
      .clk_i(clk_i),
      .we_i(cam_we),
      .addr_i(2'(adr_i[3:2] - 2'h1)),
      .wdata_i(dat_i[8:0]),
      .rdata_o(cam_rd)
   );

   // Overshoot past top dead centre, measured at rest
   assign over = (crank_angle_i > 9'h0 && crank_angle_i < 9'h05a)
                 ? crank_angle_i : 9'h0;
   // Compensated target, clamped at the earliest limit
   assign target = (tstop_q - over < ANG_TSTOP_MIN || over >= tstop_q)
                   ? ANG_TSTOP_MIN : 9'(tstop_q - over); // R6 R7

   // Next-state logic for the whole block
   always_comb begin
      opt_d = opt_q;
      strap_done_d = 1'b1;
      carry_d = carry_q;
      stoplim_d = stoplim_q;
      tstop_d = tstop_q;
      tick_cnt_d = tick_cnt_q + 15'h1;
      tick_d = 1'b0;
      win_d = win_q;
      win_on_d = win_on_q;
      blocked_d = blocked_q;
      st_d = st_q;
      stroke_d = stroke_q;
      estop_d = 1'b0;
      tstop_out_d = 1'b0;
      rest_d = at_rest_i;
      ack_d = cyc_i & stb_i & ~ack_q;
      cam_wait_d = 1'b0;
      dat_d = 32'h0;
      // Switches caught once after reset release only
      if (!strap_done_q) begin
         opt_d = option_switch_block_i; // R16
      end
      // Fixed tick from the clock
      if (tick_cnt_q == 15'(TICK_CYCLES - 1)) begin
         tick_cnt_d = 15'h0;
         tick_d = 1'b1; // R17
      end
      // Palm concurrency window
      if (!any_palm) begin
         win_on_d = 1'b0;
         blocked_d = 1'b0;
         win_d = 13'h0;
      end else if (!win_on_q && !blocked_q) begin
         win_on_d = 1'b1;
         win_d = 13'h0;
      end else if (win_on_q && tick_q) begin
         win_d = win_q + 13'h1; // R17
         if (win_q + 13'h1 >= win_lim && !all_palm) begin
            win_on_d = 1'b0;
            blocked_d = 1'b1; // R11
         end
      end
      // Stroke sequencer
      case (st_q)
         ST_IDLE: begin
            stroke_d = 1'b0;
            if (foot_mode_i && single_stroke_i && foot_pedal_i) begin // R1
               stroke_d = 1'b1;
               st_d = opt_q[SW_FOOT] ? ST_CARRY : ST_RUN; // R2 R3
            end else if (!foot_mode_i && win_on_q && all_palm) begin
               stroke_d = 1'b1; // R9 R10
               st_d = ST_RUN;
               blocked_d = 1'b1;
               win_on_d = 1'b0;
            end
         end
         ST_CARRY: begin
            if (!foot_pedal_i) begin
               stroke_d = 1'b0;
               estop_d = 1'b1; // R4
               st_d = ST_ESTOP;
            end else if (crank_angle_i >= carry_q) begin
               st_d = ST_RUN; // R3
            end
         end
         ST_RUN: begin
            if (crank_angle_i >= tstop_q) begin
               stroke_d = 1'b0;
               tstop_out_d = 1'b1;
               st_d = ST_IDLE; // R2
            end
         end
         ST_ESTOP: begin
            if (!foot_pedal_i && at_rest_i) begin
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      // On arrival at rest, step halfway toward the compensated angle
      if (at_rest_i && !rest_q && opt_q[SW_COMP] && over != 9'h0) begin // R5
         tstop_d = 9'((10'(tstop_q) + 10'(target)) >> 1); // R8
         if (tstop_d < ANG_TSTOP_MIN) begin
            tstop_d = ANG_TSTOP_MIN; // R7
         end
      end
      // Register writes
      if (wr && adr_i == A_CARRY && !opt_q[SW_LOCK] && sel_i[0]) begin
         carry_d = dat_i[8:0]; // R14
      end
      if (wr && adr_i == A_STOPLIM && !opt_q[SW_LOCK] && sel_i[0]) begin
         stoplim_d = dat_i[15:0]; // R14
      end
      // Operator top-stop angle; a bus write wins over compensation
      if (wr && adr_i == A_TSTOP && sel_i[0]) begin
         tstop_d = (dat_i[8:0] < ANG_TSTOP_MIN) ? ANG_TSTOP_MIN
                   : dat_i[8:0]; // R7
      end
      // Cam memory data lag their address by a cycle, so hold ack back
      if (rd && cam_sel && !cam_wait_q) begin
         ack_d = 1'b0;
         cam_wait_d = 1'b1;
      end
      // Register reads; unmapped reads return zero
      if (rd) begin
         case (adr_i)
            A_STATUS: dat_d = {28'h0, blocked_q, win_on_q, st_q};
            A_OPTIONS: dat_d = {24'h0, opt_q};
            A_CARRY: dat_d = {23'h0, carry_q};
            A_STOPLIM: dat_d = {16'h0, stoplim_q};
            A_TSTOP: dat_d = {23'h0, tstop_q};
            default: dat_d = cam_sel ? {23'h0, cam_rd} : 32'h0;
         endcase
      end
   end

   // Registers; switch defaults are off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opt_q <= OPT_RST; // R15
         strap_done_q <= 1'b0;
         carry_q <= CARRY_UP_RST;
         stoplim_q <= STOP_LIMIT_RST;
         tstop_q <= ANG_TSTOP_MIN;
         tick_cnt_q <= 15'h0;
         tick_q <= 1'b0;
         win_q <= 13'h0;
         win_on_q <= 1'b0;
         blocked_q <= 1'b0;
         st_q <= ST_IDLE;
         stroke_q <= 1'b0;
         estop_q <= 1'b0;
         tstop_out_q <= 1'b0;
         rest_q <= 1'b1;
         ack_q <= 1'b0;
         cam_wait_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         opt_q <= opt_d;
         strap_done_q <= strap_done_d;
         carry_q <= carry_d;
         stoplim_q <= stoplim_d;
         tstop_q <= tstop_d;
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
         win_q <= win_d;
         win_on_q <= win_on_d;
         blocked_q <= blocked_d;
         st_q <= st_d;
         stroke_q <= stroke_d;
         estop_q <= estop_d;
         tstop_out_q <= tstop_out_d;
         rest_q <= rest_d;
         ack_q <= ack_d;
         cam_wait_q <= cam_wait_d;
         dat_q <= dat_d;
      end
   end

   assign stroke_o = stroke_q;
   assign estop_o = estop_q;
   assign top_stop_o = tstop_out_q;
   assign ack_o = ack_q;
   assign dat_o = dat_q;

   // Assertions
   a_tstop_floor: assert property (@(posedge clk_i) disable iff (rst_i)
      tstop_q >= ANG_TSTOP_MIN) else $error("top-stop angle below floor"); // R7
   a_early_release: assert property (@(posedge clk_i) disable iff (rst_i)
      st_q == ST_CARRY && !foot_pedal_i |=> estop_q && !stroke_q)
      else $error("no estop on early release"); // R4
   a_opt_stable: assert property (@(posedge clk_i) disable iff (rst_i)
      strap_done_q |=> $stable(opt_q)) else $error("options changed"); // R16
   a_lock_carry: assert property (@(posedge clk_i) disable iff (rst_i)
      opt_q[SW_LOCK] |=> $stable(carry_q)) else $error("carry-up changed"); // R14
   a_no_comp: assert property (@(posedge clk_i) disable iff (rst_i)
      !opt_q[SW_COMP] && strap_done_q && !wr |=> $stable(tstop_q))
      else $error("compensation while off"); // R5
   a_expired_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
      blocked_q && !foot_mode_i && st_q == ST_IDLE |=> !stroke_q)
      else $error("start after window expiry"); // R11
   a_foot_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      st_q == ST_IDLE && foot_mode_i && single_stroke_i && foot_pedal_i
      |=> stroke_q) else $error("pedal did not start stroke"); // R2
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_q |=> !ack_q) else $error("ack held two cycles");
   c_estop: cover property (@(posedge clk_i) estop_q);
   c_palm_start: cover property (@(posedge clk_i) st_q == ST_IDLE
      && !foot_mode_i && win_on_q && all_palm);
   c_expire: cover property (@(posedge clk_i) blocked_q && any_palm);
   // Compensation step and a cam read with its wait state
   c_comp_step: cover property (@(posedge clk_i) at_rest_i && !rest_q
      && opt_q[SW_COMP] && over != 9'h0);
   c_cam_read: cover property (@(posedge clk_i) cam_wait_q && ack_d);
endmodule : posl_top
`default_nettype wire

// File: verification/posl_press_model.sv
// Behavioural clutch and crank of the press on the far side
`timescale 1ns/1ps
`default_nettype none
module posl_press_model #(
   parameter int COAST = 148 // Degrees coasted after the clutch drops
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic stroke_i,
   output logic [8:0] crank_angle_o,
   output logic at_rest_o
);
   logic [7:0] coast_q; // Degrees still to coast under the brake
   // Crank turns one degree a cycle while driven or coasting; a stop
   // issued at the factory angle lands exactly on top dead centre
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crank_angle_o <= 9'h000;
         at_rest_o <= 1'b1;
         coast_q <= 8'h00;
      end else begin
         at_rest_o <= !stroke_i && coast_q == 8'h00;
         if (stroke_i) begin
            coast_q <= 8'(COAST);
         end else if (coast_q != 8'h00) begin
            coast_q <= coast_q - 8'h01;
         end
         if (stroke_i || coast_q != 8'h00) begin
            // Wrap at top dead centre, 360 is angle 0
            crank_angle_o <= (crank_angle_o == 9'h167) ? 9'h000
               : crank_angle_o + 9'h001;
         end
      end
   end
endmodule : posl_press_model
`default_nettype wire

// File: verification/press_option_switch_logic_bench.sv
// Self-checking bench for the press option switch logic
`timescale 1ns/1ps
`default_nettype none
module press_option_switch_logic_bench;
   import posl_pkg::*;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
   logic [7:0] adr = 8'h00, sw = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, r;
   logic fm = 0, ss = 1, pedal = 0, stroke, estop, tstop, rest;
   logic [3:0] palm = 4'h0;
   logic [1:0] stn = 2'b01;
   logic [8:0] crank;
   int n_fail = 0, check_count = 0;
   // Reset-value rows: address and expected read data
   logic [7:0] ra [5] = '{A_OPTIONS, A_CARRY, A_STOPLIM, A_TSTOP, 8'h40};
   logic [31:0] rx [5] = '{32'h0, 32'hb4, 32'hc8, 32'hd3, 32'h0};
   // Short tick so the palm window is 2000 cycles
   posl_top #(.NSTAT(2), .TICK_CYCLES(4)) posl_top_inst (.clk_i(clk),
      .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .option_switch_block_i(sw), .foot_mode_i(fm), .single_stroke_i(ss),
      .foot_pedal_i(pedal), .palm_i(palm), .station_present_i(stn),
      .crank_angle_i(crank), .at_rest_i(rest), .stroke_o(stroke),
      .estop_o(estop), .top_stop_o(tstop));
   posl_press_model posl_press_model_inst (.clk_i(clk), .rst_i(rst),
      .stroke_i(stroke), .crank_angle_o(crank), .at_rest_o(rest));
   // 50 ns clock
   initial begin
      forever #25 clk = !clk;
   end
   task conclude;
      if (n_fail == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Reset with a switch setting; held 8 cycles
   task reset(input logic [7:0] o);
      sw <= o;
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : reset
   // Classic Wishbone cycle, held until ack is sampled
   // Waits as long as the slave needs; only the watchdog ends a hang
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
      @(posedge clk);
      while (ack !== 1'b1) begin
         @(posedge clk);
      end
      r = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk);
      chk({31'h0, ack}, 0);
   endtask : wb
   // Bounded wait for stroke, top-stop, stroke low or e-stop
   task wt(input int k, input int lim);
      bit hit;
      hit = 0;
      for (int n = 0; n < lim && !hit; n++) begin
         @(posedge clk);
         case (k)
            0: hit = (stroke === 1'b1);
            1: hit = (tstop === 1'b1);
            2: hit = (stroke === 1'b0);
            default: hit = (estop === 1'b1);
         endcase
      end
      chk({31'h0, hit}, 1);
   endtask : wt
   initial begin
      reset(8'h00);
      for (int i = 0; i < 5; i++) begin
         wb(0, ra[i], 0);
         chk(r, rx[i]);
      end
      // Switch change after power-up must not take hold
      sw <= 8'h40;
      wb(1, A_CARRY, 32'ha0);
      wb(0, A_CARRY, 0);
      chk(r, 32'ha0);
      wb(0, A_OPTIONS, 0);
      chk(r, 32'h0);
      // Foot mode outside single stroke: pedal is ignored
      fm <= 1'b1;
      ss <= 1'b0;
      pedal <= 1'b1;
      repeat (10) @(posedge clk);
      chk(stroke, 0);
      pedal <= 1'b0;
      ss <= 1'b1;
      @(posedge clk);
      // Foot trip: one-cycle tap completes a stroke
      pedal <= 1'b1;
      @(posedge clk);
      pedal <= 1'b0;
      wt(0, 5);
      repeat (30) @(posedge clk);
      chk(stroke, 1);
      wt(1, 400);
      chk(crank >= 9'h0d3 && crank <= 9'h0d5, 1);
      wt(2, 500);
      // Two palms together start a stroke
      fm <= 1'b0;
      repeat (200) @(posedge clk);
      palm <= 4'h3;
      wt(0, 5);
      wt(1, 400);
      palm <= 4'h0;
      wt(2, 500);
      repeat (200) @(posedge clk);
      // Second palm after the window has run out
      palm <= 4'h1;
      repeat (2100) @(posedge clk);
      palm <= 4'h3;
      repeat (20) @(posedge clk);
      chk(stroke, 0);
      palm <= 4'h0;
      // Two stations, switch 5 on: second pair late but inside 5 s
      reset(8'h10);
      stn <= 2'b11;
      palm <= 4'h3;
      repeat (2100) @(posedge clk);
      palm <= 4'hf;
      wt(0, 5);
      wt(1, 400);
      palm <= 4'h0;
      stn <= 2'b01;
      // Stop 10 degrees past top dead centre, compensation off then on
      for (int c = 0; c < 2; c++) begin
         reset(c ? 8'h08 : 8'h00);
         wb(1, A_TSTOP, 32'hdd);
         fm <= 1'b1;
         pedal <= 1'b1;
         @(posedge clk);
         pedal <= 1'b0;
         wt(1, 400);
         repeat (200) @(posedge clk);
         wb(0, A_TSTOP, 0);
         chk(r, c ? 32'hd8 : 32'hdd);
      end
      // Cam angle taken with switch 6 on, refused with it off
      reset(8'h20);
      wb(1, A_CAM0, 32'h5a);
      wb(0, A_CAM0, 0);
      chk(r, 32'h5a);
      reset(8'h00);
      wb(1, A_CAM0, 32'h33);
      wb(0, A_CAM0, 0);
      chk(r, 32'h5a);
      // Hold-to-run: held past carry-up completes, early release stops
      reset(8'h44);
      fm <= 1'b1;
      pedal <= 1'b1;
      wt(0, 5);
      repeat (195) @(posedge clk);
      pedal <= 1'b0;
      wt(1, 400);
      repeat (200) @(posedge clk);
      pedal <= 1'b1;
      wt(0, 5);
      repeat (20) @(posedge clk);
      pedal <= 1'b0;
      wt(3, 5);
      wt(2, 5);
      wb(1, A_CARRY, 32'h50);
      wb(0, A_CARRY, 0);
      chk(r, 32'hb4);
      conclude;
   end
   // Watchdog over the whole run
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      conclude;
   end
endmodule : press_option_switch_logic_bench
`default_nettype wire
